// File: rtl/arcf_pkg.sv
// Constants shared by the receive cell filter.
package arcf_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CFG = 8'h00;
  localparam logic [7:0] REG_DEL = 8'h04;
  localparam logic [7:0] REG_PORT = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0C;
  localparam int CFG_DETONLY = 0;
  localparam int CFG_NODISC = 1;
  localparam int CFG_COSET = 8;
  localparam int CFG_ALPHA = 16;
  localparam int CFG_DELTA = 20;
  localparam int DEL_MATCH = 0;
  localparam int DEL_MASK = 8;
  localparam int PORT_MODE = 0;
  localparam int PORT_ACT = 2;
  localparam int PORT_DSOFF = 3;
  localparam int PORT_DELEN = 4;
  localparam int PORT_CDIS = 5;
  localparam logic [7:0] COSET_RST = 8'h55;
  localparam logic [3:0] ALPHA_RST = 4'h7;
  localparam logic [3:0] DELTA_RST = 4'h6;
  localparam logic [7:0] MATCH_RST = 8'h01;
  localparam logic [7:0] MASK_RST = 8'h00;
  // ----------------------------------------------------------------
  // Modes, states and timing
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_INACTIVE = 2'h0;
  localparam logic [1:0] MODE_STANDBY = 2'h2;
  localparam logic [7:0] HEC_POLY = 8'h07;
  localparam logic [5:0] POS_HEC = 6'h04;
  localparam logic [5:0] POS_PL0 = 6'h05;
  localparam logic [5:0] POS_LAST = 6'h34;
  localparam int CLK_NS = 100;
  localparam int ACT_HOLD_NS = 250000;
  localparam int ACT_HOLD_CYC = (ACT_HOLD_NS + CLK_NS - 1) / CLK_NS;
  typedef enum logic [2:0] {HUNT = 3'b001, PRESYNC = 3'b010, SYNC = 3'b100} arcf_delin_e;
  typedef enum logic [1:0] {CORR = 2'b01, DET = 2'b10} arcf_hec_e;
endpackage

// File: rtl/arcf_cell_filter.sv
// Receive cell filter: delineation, HEC check, descrambling, cell deletion.
//
// Function
// - Correction mode repairs single-bit header errors.
// - Drop multi-bit errors, or any in detection.
// - Config bit selects detection-only HEC algorithm.
// - No-discard forwards errored cells unless PORT_CDIS is set on the port, flags UDF bit7.
// - Per-port switchable x43+1 payload descrambler.
// - Delete match on eight header bits, rest zero.
// - Mask bits make compared bits don't-care.
// - Per-port enable for cell deletion.
// - Inactive port takes no framer data.
// - Active port stores cells, queues their addresses.
// - Standby port delineates but writes nothing.
// - Discard octets while delineation is not SYNC.
// - Remove coset from HEC before syndrome.
// - Syndrome over four octets, x8+x2+x+1, zero start.
//
// Design decisions made here: the address map and the strobed register port.
`timescale 1ns/1ps
module arcf_cell_filter #(
  parameter int SLOT_W = 4
) (
  input wire logic mclk, // 10 MHz core clock
  input wire logic resetn, // Asynchronous reset, active low
  input wire logic [7:0] regAddr, // Register byte address
  input wire logic [31:0] regWdata, // Register write data
  input wire logic regWr, // Write strobe
  input wire logic regRd, // Read strobe
  output logic [31:0] regRdata, // Read data, cycle after strobe
  input wire logic [7:0] frOctet, // Framer octet pins
  input wire logic frToggle, // Toggles once per framer octet
  output logic hdrWrite, // Header of a kept cell
  output logic [31:0] hdrData, // Corrected header octets 1..4
  output logic bufWrite, // Payload octet write
  output logic [5:0] bufIdx, // Payload octet index 0..47
  output logic [7:0] bufData, // Descrambled payload octet
  output logic [SLOT_W-1:0] bufSlot, // Buffer slot of the cell
  output logic queuePush, // Stored cell address to output queue
  output logic [SLOT_W-1:0] queueSlot, // Slot of the pushed cell
  output logic [7:0] queueUdf // UDF octet for the cell
);
  // ----------------------------------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] rstSync;
  logic rstn;
  logic [7:0] octS1, octS2;
  logic tgS1, tgS2, tgS3;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) rstSync <= 2'h0;
    else rstSync <= {rstSync[0], 1'b1};
  end
  assign rstn = rstSync[1];
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      octS1 <= 8'h00;
      octS2 <= 8'h00;
      {tgS1, tgS2, tgS3} <= 3'h0;
    end else begin
      octS1 <= frOctet;
      octS2 <= octS1;
      {tgS1, tgS2, tgS3} <= {frToggle, tgS1, tgS2};
    end
  end

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic [7:0] crc32(input logic [31:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 31; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? arcf_pkg::HEC_POLY : 8'h00);
    end
    return c;
  endfunction
  // Constant syndrome table folded by synthesis: one hit per error bit.
  function automatic logic [39:0] fixMask(input logic [7:0] s);
    logic [39:0] m, e;
    m = 40'h0;
    for (int i = 0; i < 40; i++) begin
      e = 40'h1 << i;
      if ((crc32(e[39:8]) ^ e[7:0]) == s && s != 8'h00) m[i] = 1'b1;
    end
    return m;
  endfunction
  function automatic logic [50:0] descr(input logic [42:0] st, input logic [7:0] d);
    logic [42:0] s;
    logic [7:0] o;
    s = st;
    o = 8'h00;
    for (int b = 7; b >= 0; b--) begin
      o[b] = d[b] ^ s[42];
      s = {s[41:0], d[b]};
    end
    return {s, o};
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic detOnly, noDisc, dsOff, delEn, cellDis, portAct, portReady;
  logic [7:0] coset, delMatch, delMask;
  logic [3:0] alpha, delta;
  logic [1:0] chMode;
  logic [11:0] actCnt;
  arcf_pkg::arcf_delin_e delin;
  arcf_pkg::arcf_hec_e hecSt;
  wire [31:0] cfgWord = {8'h00, delta, alpha, coset, 6'h00, noDisc, detOnly};
  wire [31:0] delWord = {16'h0000, delMask, delMatch};
  wire [31:0] portWord = {26'h0, cellDis, delEn, dsOff, portAct, chMode};
  wire [31:0] statWord = {27'h0, portReady, hecSt == arcf_pkg::DET, delin};
  wire [31:0] rdMux = (regAddr == arcf_pkg::REG_CFG) ? cfgWord :
                      (regAddr == arcf_pkg::REG_DEL) ? delWord :
                      (regAddr == arcf_pkg::REG_PORT) ? portWord :
                      (regAddr == arcf_pkg::REG_STAT) ? statWord : 32'h0;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      {detOnly, noDisc, dsOff, delEn, cellDis, portAct} <= 6'h00;
      coset <= arcf_pkg::COSET_RST;
      alpha <= arcf_pkg::ALPHA_RST;
      delta <= arcf_pkg::DELTA_RST;
      delMatch <= arcf_pkg::MATCH_RST;
      delMask <= arcf_pkg::MASK_RST;
      chMode <= arcf_pkg::MODE_INACTIVE;
      regRdata <= 32'h0;
    end else begin
      regRdata <= regRd ? rdMux : 32'h0;
      if (regWr && regAddr == arcf_pkg::REG_CFG) begin
        detOnly <= regWdata[arcf_pkg::CFG_DETONLY];
        noDisc <= regWdata[arcf_pkg::CFG_NODISC];
        coset <= regWdata[arcf_pkg::CFG_COSET +: 8];
        alpha <= regWdata[arcf_pkg::CFG_ALPHA +: 4];
        delta <= regWdata[arcf_pkg::CFG_DELTA +: 4];
      end
      if (regWr && regAddr == arcf_pkg::REG_DEL) begin
        delMatch <= regWdata[arcf_pkg::DEL_MATCH +: 8];
        delMask <= regWdata[arcf_pkg::DEL_MASK +: 8];
      end
      if (regWr && regAddr == arcf_pkg::REG_PORT) begin
        chMode <= regWdata[arcf_pkg::PORT_MODE +: 2];
        portAct <= regWdata[arcf_pkg::PORT_ACT];
        dsOff <= regWdata[arcf_pkg::PORT_DSOFF];
        delEn <= regWdata[arcf_pkg::PORT_DELEN];
        cellDis <= regWdata[arcf_pkg::PORT_CDIS];
      end
    end
  end

  // ----------------------------------------------------------------
  // Port activation: the hold step resets the port before it may run
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      actCnt <= 12'h000;
      portReady <= 1'b0;
    end else if (!portAct) begin
      actCnt <= 12'h000;
      portReady <= 1'b0;
    end else if (chMode == arcf_pkg::MODE_INACTIVE && !portReady) begin
      actCnt <= actCnt + 12'h001;
      portReady <= (actCnt == 12'(arcf_pkg::ACT_HOLD_CYC - 1));
    end
  end
  wire portOn = portAct && portReady && chMode != arcf_pkg::MODE_INACTIVE;
  wire active = portOn && chMode[0];
  wire newOct = (tgS2 ^ tgS3) && portOn;

  // ----------------------------------------------------------------
  // Header check on the latest five octets
  // ----------------------------------------------------------------
  logic [31:0] win;
  logic [5:0] pos;
  logic [4:0] dCnt;
  logic [42:0] dsState;
  logic cellKeep, cellErr;
  wire [31:0] hdr = win;
  wire [7:0] syn = crc32(hdr) ^ octS2 ^ coset;
  wire hecOk = (syn == 8'h00);
  wire [39:0] fix = fixMask(syn);
  wire [31:0] fixHdr = fix[39:8];
  wire detMode = detOnly || hecSt == arcf_pkg::DET;
  wire correctable = !detMode && (fix != 40'h0);
  wire [31:0] outHdr = correctable ? hdr ^ fix[39:8] : hdr;
  wire [7:0] cmpBits = {outHdr[31:28], outHdr[3:0]};
  wire delHit = delEn && ((cmpBits ^ delMatch) & ~delMask) == 8'h00
                && outHdr[27:4] == 24'h0;
  wire hdrBad = !hecOk && !correctable;
  wire evalHdr = newOct && delin == arcf_pkg::SYNC && pos == arcf_pkg::POS_HEC;
  wire drop = (hdrBad && (!noDisc || cellDis)) || delHit || !active;
  wire payload = newOct && delin == arcf_pkg::SYNC && pos >= arcf_pkg::POS_PL0;
  wire [50:0] ds = descr(dsState, octS2);
  wire [4:0] dInc = dCnt + 5'h01;

  // ----------------------------------------------------------------
  // Cell delineation
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      delin <= arcf_pkg::HUNT;
      pos <= 6'h00;
      dCnt <= 5'h00;
      win <= 32'h0;
    end else if (!portOn) begin
      delin <= arcf_pkg::HUNT;
      dCnt <= 5'h00;
    end else if (newOct) begin
      win <= {win[23:0], octS2};
      pos <= (pos == arcf_pkg::POS_LAST) ? 6'h00 : pos + 6'h01;
      unique case (delin)
        arcf_pkg::HUNT: begin
          if (hecOk) begin
            delin <= arcf_pkg::PRESYNC;
            pos <= arcf_pkg::POS_PL0;
            dCnt <= 5'h00;
          end
        end
        arcf_pkg::PRESYNC: begin
          if (pos == arcf_pkg::POS_HEC && !hecOk) delin <= arcf_pkg::HUNT;
          else if (pos == arcf_pkg::POS_HEC) begin
            dCnt <= (dInc >= {1'b0, delta}) ? 5'h00 : dInc;
            if (dInc >= {1'b0, delta}) delin <= arcf_pkg::SYNC;
          end
        end
        arcf_pkg::SYNC: begin
          if (pos == arcf_pkg::POS_HEC) begin
            dCnt <= (hecOk || dInc >= {1'b0, alpha}) ? 5'h00 : dInc;
            if (!hecOk && dInc >= {1'b0, alpha}) delin <= arcf_pkg::HUNT;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // HEC mode machine and cell output
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) hecSt <= arcf_pkg::CORR;
    else if (detOnly) hecSt <= arcf_pkg::DET;
    else if (delin != arcf_pkg::SYNC) hecSt <= arcf_pkg::CORR;
    else if (evalHdr) hecSt <= hecOk ? arcf_pkg::CORR : arcf_pkg::DET;
  end
  // Descrambler state follows every payload octet, kept or not, so that
  // it stays locked to the line even across dropped cells.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      dsState <= 43'h0;
      {cellKeep, cellErr, hdrWrite, bufWrite, queuePush} <= 5'h00;
      hdrData <= 32'h0;
      bufIdx <= 6'h00;
      bufData <= 8'h00;
      bufSlot <= '0;
      queueSlot <= '0;
      queueUdf <= 8'h00;
    end else begin
      hdrWrite <= evalHdr && !drop;
      bufWrite <= payload && cellKeep;
      queuePush <= payload && cellKeep && pos == arcf_pkg::POS_LAST;
      if (delin != arcf_pkg::SYNC || !active) cellKeep <= 1'b0;
      if (evalHdr) begin
        cellKeep <= !drop;
        cellErr <= !hecOk && noDisc;
        hdrData <= outHdr;
      end
      if (payload) begin
        dsState <= ds[50:8];
        bufData <= dsOff ? octS2 : ds[7:0];
        bufIdx <= pos - arcf_pkg::POS_PL0;
      end
      if (payload && cellKeep && pos == arcf_pkg::POS_LAST) begin
        queueSlot <= bufSlot;
        queueUdf <= {cellErr, 7'h00};
        bufSlot <= bufSlot + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  a_inactive_quiet: assert property (
    chMode == arcf_pkg::MODE_INACTIVE |-> ##1 !hdrWrite)
    else $error("header written while port inactive");
  a_standby_nowrite: assert property (
    $past(chMode) == arcf_pkg::MODE_STANDBY && $past(chMode, 2) == arcf_pkg::MODE_STANDBY
    |-> !hdrWrite && !bufWrite && !queuePush)
    else $error("standby port wrote a cell");
  a_nosync_discard: assert property (
    hdrWrite |-> $past(delin) == arcf_pkg::SYNC && $past(pos) == arcf_pkg::POS_HEC)
    else $error("header stored outside SYNC");
  a_detect_drop: assert property (
    evalHdr && detMode && !hecOk && !noDisc |=> !hdrWrite ##1 !bufWrite)
    else $error("errored cell kept in detection");
  a_single_fix: assert property (
    evalHdr && hecSt == arcf_pkg::CORR && !detOnly && fix != 40'h0 && active && !delHit
    |=> hdrWrite && hdrData == ($past(win) ^ $past(fixHdr)))
    else $error("single-bit error not corrected");
  a_hec_state: assert property (
    evalHdr && !hecOk |=> hecSt == arcf_pkg::DET)
    else $error("HEC machine did not enter detection");
  a_detect_only: assert property (
    detOnly |=> hecSt == arcf_pkg::DET)
    else $error("detection-only algorithm kept correction state");
  a_delete_match: assert property (
    evalHdr && delHit |=> !hdrWrite)
    else $error("deletable cell passed");
  a_udf_flag: assert property (
    queuePush && queueUdf[7] |-> $past(noDisc, 2) || $past(noDisc))
    else $error("UDF flag without no-discard");
  a_descr_off: assert property (
    payload && cellKeep && dsOff |=> bufWrite && bufData == $past(octS2))
    else $error("payload altered with descrambler off");
endmodule // arcf_cell_filter

// File: testbench/arcf_framer_model.sv
// Framer model that streams whole cells octet by octet toward the filter.
`timescale 1ns/1ps
module arcf_framer_model #(
  parameter int GAP = 5
) (
  input wire logic mclk, // Core clock
  output logic [7:0] frOctet, // Octet pins
  output logic frToggle // One toggle per octet
);
  initial begin
    frOctet = 8'h00;
    frToggle = 1'b0;
  end
  function automatic logic [7:0] hec(input logic [31:0] h);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 31; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ h[i]) ? 8'h07 : 8'h00);
    end
    return c ^ 8'h55;
  endfunction
  // The octet stands from one cycle before its toggle until the next one.
  task automatic put(input logic [7:0] o);
    frOctet <= o;
    @(posedge mclk);
    frToggle <= ~frToggle;
    repeat (GAP) @(posedge mclk);
  endtask
  task automatic send_cell(input logic [31:0] h, input logic [39:0] flip, input logic [7:0] p);
    logic [39:0] raw;
    raw = {h, hec(h)} ^ flip;
    for (int i = 4; i >= 0; i--) begin
      put(raw[i*8 +: 8]);
    end
    repeat (48) put(p);
  endtask
endmodule // arcf_framer_model

// File: testbench/arcf_cell_filter_bench.sv
// Self-checking bench for the receive cell filter.
`timescale 1ns/1ps
module arcf_cell_filter_bench;
  logic mclk = 1'b0;
  logic resetn;
  logic [7:0] regAddr;
  logic [31:0] regWdata;
  logic regWr;
  logic regRd;
  logic [31:0] regRdata;
  logic [7:0] frOctet;
  logic frToggle;
  logic hdrWrite;
  logic [31:0] hdrData;
  logic bufWrite;
  logic [5:0] bufIdx;
  logic [7:0] bufData;
  logic [3:0] bufSlot;
  logic queuePush;
  logic [3:0] queueSlot;
  logic [7:0] queueUdf;
  int errorCnt = 0;
  int nTests = 0;
  int nHdr = 0;
  int nPush = 0;
  int nBuf = 0;
  logic [31:0] lastHdr;
  logic [7:0] lastBuf;
  logic [7:0] lastUdf;
  logic [31:0] rd;
  localparam logic [31:0] CFG0 = 32'h0067_5500;
  localparam logic [31:0] HA = 32'h0123_4560;

  always #50 mclk = ~mclk;

  arcf_cell_filter DUT (
    .mclk(mclk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .frOctet(frOctet),
    .frToggle(frToggle), .hdrWrite(hdrWrite), .hdrData(hdrData), .bufWrite(bufWrite),
    .bufIdx(bufIdx), .bufData(bufData), .bufSlot(bufSlot), .queuePush(queuePush),
    .queueSlot(queueSlot), .queueUdf(queueUdf)
  );
  arcf_framer_model FR (.mclk(mclk), .frOctet(frOctet), .frToggle(frToggle));

  always @(posedge mclk) begin
    if (hdrWrite === 1'b1) begin
      nHdr++;
      lastHdr = hdrData;
    end
    if (bufWrite === 1'b1) begin
      nBuf++;
      lastBuf = bufData;
    end
    if (queuePush === 1'b1) begin
      chk("queue slot", 32'(nPush % 16), 32'(queueSlot));
      chk("next buffer slot", 32'((nPush + 1) % 16), 32'(bufSlot));
      nPush++;
      lastUdf = queueUdf;
      chk("index at push", 32'd47, 32'(bufIdx));
    end
  end

  // ------------------------------------------------------------
  // Bus and cell helpers
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    nTests++;
    if (got !== exp) begin
      errorCnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // A gap cycle follows each strobe so no strobe is driven twice at one edge.
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic reg_rd(input logic [7:0] a);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    #1 rd = regRdata;
    @(posedge mclk);
  endtask
  task automatic set_port(input logic [1:0] md, input logic ds, input logic dl, input logic cd);
    reg_wr(arcf_pkg::REG_PORT, {26'h0, cd, dl, ds, 1'b1, md});
  endtask
  task automatic run_cell(input logic [31:0] h, input logic [39:0] flip, input logic [7:0] p,
      input logic pass, input logic [31:0] eh, input logic [7:0] ep, input logic flag);
    int h0;
    int p0;
    int b0;
    h0 = nHdr;
    p0 = nPush;
    b0 = nBuf;
    FR.send_cell(h, flip, p);
    repeat (3) @(posedge mclk);
    chk("header pulses", 32'(pass), 32'(nHdr - h0));
    chk("queue pushes", 32'(pass), 32'(nPush - p0));
    chk("payload writes", pass ? 32'd48 : 32'd0, 32'(nBuf - b0));
    if (pass) begin
      chk("header", eh, lastHdr);
      chk("payload", 32'(ep), 32'(lastBuf));
      chk("error flag", 32'(flag), 32'(lastUdf[7]));
    end
  endtask
  task automatic del_case(input logic [15:0] mm, input logic en, input logic [31:0] h,
      input logic pass);
    reg_wr(arcf_pkg::REG_DEL, {16'h0, mm});
    set_port(2'b01, 1'b1, en, 1'b0);
    run_cell(h, 40'h0, 8'h77, pass, h, 8'h77, 1'b0);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_activate();
    reg_rd(arcf_pkg::REG_CFG);
    chk("config reset", CFG0, rd);
    reg_rd(arcf_pkg::REG_DEL);
    chk("deletion reset", 32'h1, rd);
    reg_wr(arcf_pkg::REG_PORT, 32'h0);
    reg_wr(arcf_pkg::REG_PORT, 32'h4);
    reg_rd(arcf_pkg::REG_STAT);
    chk("early ready", 32'h0, 32'(rd[4]));
    repeat (10) FR.send_cell(HA, 40'h0, 8'h3C);
    chk("inactive pulses", 32'h0, 32'(nHdr + nBuf + nPush));
    reg_rd(arcf_pkg::REG_STAT);
    chk("ready and hunting", 32'h11, 32'(rd[4:0]));
  endtask
  task automatic t_standby();
    set_port(2'b10, 1'b1, 1'b0, 1'b0);
    repeat (10) FR.send_cell(HA, 40'h0, 8'h3C);
    chk("standby pulses", 32'h0, 32'(nHdr + nBuf + nPush));
    reg_rd(arcf_pkg::REG_STAT);
    chk("delineation", 32'h4, 32'(rd[2:0]));
  endtask
  task automatic t_hec();
    set_port(2'b01, 1'b1, 1'b0, 1'b0);
    run_cell(HA, 40'h0, 8'h3C, 1'b1, HA, 8'h3C, 1'b0);
    run_cell(HA, 40'h80_0000, 8'hC3, 1'b1, HA, 8'hC3, 1'b0);
    run_cell(HA, 40'h80_0000, 8'hC3, 1'b0, HA, 8'hC3, 1'b0);
    run_cell(HA, 40'h0, 8'h5A, 1'b1, HA, 8'h5A, 1'b0);
    run_cell(HA, 40'h81_0000, 8'h5A, 1'b0, HA, 8'h5A, 1'b0);
    reg_wr(arcf_pkg::REG_CFG, CFG0 | 32'h1);
    run_cell(HA, 40'h0, 8'h21, 1'b1, HA, 8'h21, 1'b0);
    run_cell(HA, 40'h80_0000, 8'h21, 1'b0, HA, 8'h21, 1'b0);
    reg_wr(arcf_pkg::REG_CFG, CFG0 | 32'h2);
    run_cell(HA, 40'h81_0000, 8'h11, 1'b1, HA ^ 32'h8100, 8'h11, 1'b1);
    run_cell(HA, 40'h0, 8'h12, 1'b1, HA, 8'h12, 1'b0);
    set_port(2'b01, 1'b1, 1'b0, 1'b1);
    run_cell(HA, 40'h81_0000, 8'h13, 1'b0, HA, 8'h13, 1'b0);
    reg_wr(arcf_pkg::REG_CFG, CFG0);
  endtask
  task automatic t_delete();
    del_case(16'h0001, 1'b1, 32'h1, 1'b0);
    del_case(16'h0001, 1'b1, 32'h9, 1'b1);
    del_case(16'hFE01, 1'b1, 32'h9, 1'b0);
    del_case(16'h0011, 1'b1, 32'h1000_0001, 1'b0);
    del_case(16'hFE00, 1'b1, 32'hE, 1'b0);
    del_case(16'hFE00, 1'b1, 32'h2E, 1'b1);
    del_case(16'hFE00, 1'b0, 32'hE, 1'b1);
  endtask
  // After 43 bits of ones in a cell the descrambled output is all zeros.
  task automatic t_descramble();
    set_port(2'b01, 1'b0, 1'b0, 1'b0);
    run_cell(HA, 40'h0, 8'hFF, 1'b1, HA, 8'h00, 1'b0);
    set_port(2'b11, 1'b1, 1'b0, 1'b0);
    run_cell(HA, 40'h0, 8'hFF, 1'b1, HA, 8'hFF, 1'b0);
  endtask

  task automatic finish_test();
    if (errorCnt == 0 && nTests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // The run needs about 1.3 ms; over twice that means a hang.
  initial begin
    #3_000_000;
    errorCnt++;
    finish_test();
  end

  initial begin
    resetn = 1'b0;
    regAddr = 8'h00;
    regWdata = 32'h0;
    regWr = 1'b0;
    regRd = 1'b0;
    repeat (10) @(posedge mclk);
    resetn <= 1'b1;
    repeat (4) @(posedge mclk);
    t_activate();
    t_standby();
    t_hec();
    t_delete();
    t_descramble();
    finish_test();
  end
endmodule // arcf_cell_filter_bench
